// ===== core/ndatb_attr_block.sv
`timescale 1ns/1ps
// decodes block 0 of user memory and classifies block accesses;
// also serialises the verify reply bytes.
module ndatb_attr_block (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [7:0] attr_wr_data,
  input wire logic [3:0] attr_wr_ofs,
  input wire logic attr_wr_en,
  input wire logic [15:0] tag_system_code,
  input wire logic [9:0] access_block,
  input wire logic access_is_write,
  input wire logic verify_start,
  input wire logic [63:0] card_id,
  input wire logic [7:0] status_flag1,
  input wire logic [7:0] status_flag2,
  output logic resp_valid,
  output logic [7:0] resp_byte,
  output logic resp_last,
  output ndatb_pkg::ndatb_attr_s attr_info_block,
  output logic ndef_enabled,
  output logic attr_valid,
  output logic write_in_progress,
  output logic attr_read_only,
  output logic access_attr,
  output logic access_file,
  output logic access_denied,
  output logic [15:0] access_byte_addr
);
  // byte store for block zero, indexed by offset within the block
  logic [7:0] mem_q [0:15];
  logic [7:0] mem_d [0:15];
  logic [15:0] wr_sel;
  logic wr_allowed;
  logic [15:0] sum;
  logic [15:0] stored_sum;
  logic sum_ok;
  logic read_limit_ok;
  logic write_limit_ok;
  logic pad_zero;
  logic block_is_attr;
  logic block_in_file;
  logic [87:0] resp_q;
  logic [87:0] resp_d;
  logic [3:0] cnt_q;
  logic [3:0] cnt_d;
  ndatb_pkg::ndatb_state_e st_q;
  ndatb_pkg::ndatb_state_e st_d;
  logic reply_load;
  logic reply_done;

  // access byte stays writable so a locked block can be reopened
  always_comb begin
    wr_allowed = attr_wr_en;
    if (attr_read_only && attr_wr_ofs != 4'(ndatb_pkg::NDATB_OFS_ACCESS)) begin
      wr_allowed = 1'b0; // RQ11
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++) begin : g_byte
      assign wr_sel[gi] = wr_allowed && (attr_wr_ofs == 4'(gi));
      always_comb begin
        mem_d[gi] = mem_q[gi];
        if (wr_sel[gi]) begin
          mem_d[gi] = attr_wr_data;
        end
      end
      always_ff @(posedge core_clk) begin
        if (rst) begin
          mem_q[gi] <= 8'h00;
        end else begin
          mem_q[gi] <= mem_d[gi];
        end
      end
    end
  endgenerate

  // sum wraps at sixteen bits; any carry out is dropped on purpose
  always_comb begin
    sum = 16'h0000;
    for (int i = 0; i < ndatb_pkg::NDATB_SUM_BYTES; i++) begin
      sum = 16'(sum + {8'h00, mem_q[i]}); // RQ13 RQ15
    end
  end

  // high byte of every field sits at the lower offset
  assign stored_sum = {mem_q[ndatb_pkg::NDATB_OFS_SUM],
                       mem_q[ndatb_pkg::NDATB_OFS_SUM + 1]}; // RQ15

  always_comb begin
    attr_info_block.version = mem_q[ndatb_pkg::NDATB_OFS_VERSION]; // RQ5
    attr_info_block.max_read = mem_q[ndatb_pkg::NDATB_OFS_MAXREAD]; // RQ6
    attr_info_block.max_write = mem_q[ndatb_pkg::NDATB_OFS_MAXWRITE]; // RQ7
    attr_info_block.max_blocks = {mem_q[ndatb_pkg::NDATB_OFS_MAXBLK],
                                  mem_q[ndatb_pkg::NDATB_OFS_MAXBLK + 1]}; // RQ8
    attr_info_block.write_progress_flag = mem_q[ndatb_pkg::NDATB_OFS_WFLAG]; // RQ10
    attr_info_block.access = mem_q[ndatb_pkg::NDATB_OFS_ACCESS]; // RQ11
    attr_info_block.message_length_field = {mem_q[ndatb_pkg::NDATB_OFS_LEN],
                                            mem_q[ndatb_pkg::NDATB_OFS_LEN + 1],
                                            mem_q[ndatb_pkg::NDATB_OFS_LEN + 2]}; // RQ12
    attr_info_block.checksum = stored_sum; // RQ13
  end

  // checks only; the configurer is trusted to fill the fields
  always_comb begin
    sum_ok = (sum == stored_sum); // RQ13
    read_limit_ok =
      (mem_q[ndatb_pkg::NDATB_OFS_MAXREAD] == ndatb_pkg::NDATB_MAX_READ); // RQ6
    write_limit_ok =
      (mem_q[ndatb_pkg::NDATB_OFS_MAXWRITE] == ndatb_pkg::NDATB_MAX_WRITE); // RQ7
    pad_zero = 1'b1;
    for (int k = ndatb_pkg::NDATB_OFS_PAD; k < ndatb_pkg::NDATB_OFS_WFLAG; k++) begin
      if (mem_q[k] != 8'h00) begin
        pad_zero = 1'b0; // RQ9
      end
    end
  end

  assign ndef_enabled = (tag_system_code == ndatb_pkg::NDATB_SYSTEM_CODE); // RQ4
  assign write_in_progress =
    (mem_q[ndatb_pkg::NDATB_OFS_WFLAG] == ndatb_pkg::NDATB_WRITE_BUSY); // RQ10
  assign attr_read_only =
    (mem_q[ndatb_pkg::NDATB_OFS_ACCESS] == ndatb_pkg::NDATB_ACCESS_RO); // RQ11
  assign attr_valid = sum_ok && ndef_enabled && read_limit_ok && write_limit_ok && pad_zero;

  // block decode is gated by the system code so a foreign layout never maps
  always_comb begin
    block_is_attr = (access_block == ndatb_pkg::NDATB_ATTR_BLOCK); // RQ2
    block_in_file = 1'b0;
    if (access_block >= ndatb_pkg::NDATB_FILE_FIRST) begin
      if (access_block <= ndatb_pkg::NDATB_FILE_LAST) begin
        block_in_file = 1'b1; // RQ3
      end
    end
  end

  assign access_attr = ndef_enabled && block_is_attr; // RQ2
  assign access_file = ndef_enabled && block_in_file; // RQ3
  assign access_denied = access_is_write && access_attr && attr_read_only; // RQ11
  // sixteen bytes a block, so the file's first block starts at its base address
  assign access_byte_addr = {2'b00, access_block, 4'h0}; // RQ3

  assign reply_load = (st_q == ndatb_pkg::NDATB_IDLE) && verify_start;
  assign reply_done = (cnt_q == 4'(ndatb_pkg::NDATB_RESP_BYTES - 1));

  // a start pulse during a reply is dropped, not queued
  always_comb begin
    st_d = st_q;
    unique case (st_q)
      ndatb_pkg::NDATB_IDLE: begin
        if (verify_start) begin
          st_d = ndatb_pkg::NDATB_SEND;
        end
      end
      ndatb_pkg::NDATB_SEND: begin
        if (reply_done) begin
          st_d = ndatb_pkg::NDATB_IDLE;
        end
      end
      default: begin
        st_d = ndatb_pkg::NDATB_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_q <= ndatb_pkg::NDATB_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  // shifter empties itself, so the byte port reads zero between replies
  always_comb begin
    resp_d = resp_q;
    if (reply_load) begin
      resp_d = {ndatb_pkg::NDATB_VERIFY_RESP_CODE, card_id, status_flag1, status_flag2}; // RQ1
    end else if (st_q == ndatb_pkg::NDATB_SEND) begin
      resp_d = {resp_q[79:0], 8'h00}; // RQ1
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      resp_q <= 88'h0;
    end else begin
      resp_q <= resp_d;
    end
  end

  always_comb begin
    cnt_d = cnt_q;
    if (reply_load) begin
      cnt_d = 4'h0;
    end else if (st_q == ndatb_pkg::NDATB_SEND) begin
      cnt_d = 4'(cnt_q + 4'h1);
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      cnt_q <= 4'h0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign resp_valid = (st_q == ndatb_pkg::NDATB_SEND);
  assign resp_byte = resp_q[87:80]; // RQ1
  assign resp_last = resp_valid && reply_done; // RQ1
endmodule : ndatb_attr_block

// ===== core/ndatb_pkg.sv
// Notes on behaviour
// RQ1 - verify reply: code 0x09, card id, two flags
// RQ2 - attribute block sits at user block zero
// RQ3 - message file spans blocks one to fifty-nine
// RQ4 - configurer programs system code 0x12fc
// RQ5 - byte zero holds mapping version
// RQ6 - byte one: max read blocks 0x0f
// RQ7 - byte two: max write blocks 0x0b
// RQ8 - bytes three-four: max data blocks
// RQ9 - bytes five to eight are zero
// RQ10 - write progress flag brackets message writes
// RQ11 - access byte: 0x00 read-only, 0x01 writable
// RQ12 - bytes eleven-thirteen hold message length
// RQ13 - checksum sums bytes zero to thirteen
// RQ14 - empty message is d0 00 00
// RQ15 - big-endian fields, checksum wraps sixteen bits
package ndatb_pkg;
  localparam logic [7:0] NDATB_VERIFY_RESP_CODE = 8'h09;
  localparam int NDATB_RESP_BYTES = 11;
  localparam logic [9:0] NDATB_ATTR_BLOCK = 10'h000;
  localparam logic [9:0] NDATB_FILE_FIRST = 10'h001;
  localparam logic [9:0] NDATB_FILE_LAST = 10'h03b;
  localparam logic [15:0] NDATB_FILE_BASE_ADDR = 16'h0010;
  localparam logic [15:0] NDATB_SYSTEM_CODE = 16'h12fc;
  localparam logic [7:0] NDATB_MAX_READ = 8'h0f;
  localparam logic [7:0] NDATB_MAX_WRITE = 8'h0b;
  localparam logic [7:0] NDATB_WRITE_BUSY = 8'h0f;
  localparam logic [7:0] NDATB_WRITE_DONE = 8'h00;
  localparam logic [7:0] NDATB_ACCESS_RO = 8'h00;
  localparam logic [7:0] NDATB_ACCESS_RW = 8'h01;
  localparam logic [23:0] NDATB_EMPTY_MSG = 24'hd00000;
  localparam logic [23:0] NDATB_EMPTY_LEN = 24'h000003;
  localparam int NDATB_SUM_BYTES = 14;
  localparam int NDATB_OFS_VERSION = 0;
  localparam int NDATB_OFS_MAXREAD = 1;
  localparam int NDATB_OFS_MAXWRITE = 2;
  localparam int NDATB_OFS_MAXBLK = 3;
  localparam int NDATB_OFS_PAD = 5;
  localparam int NDATB_OFS_WFLAG = 9;
  localparam int NDATB_OFS_ACCESS = 10;
  localparam int NDATB_OFS_LEN = 11;
  localparam int NDATB_OFS_SUM = 14;

  typedef struct packed {
    logic [7:0] version;
    logic [7:0] max_read;
    logic [7:0] max_write;
    logic [15:0] max_blocks;
    logic [7:0] write_progress_flag;
    logic [7:0] access;
    logic [23:0] message_length_field;
    logic [15:0] checksum;
  } ndatb_attr_s;

  typedef enum logic [1:0] {
    NDATB_IDLE = 2'b00,
    NDATB_SEND = 2'b01
  } ndatb_state_e;
endpackage : ndatb_pkg

// ===== verification/ndatb_rw_model.sv
`timescale 1ns/1ps
module ndatb_rw_model (
  output logic [127:0] attr_image
);
  logic [111:0] b;
  logic [15:0] sum;
  always_comb begin
    b = {8'h10, 8'h0f, 8'h0b, 16'h0018, 32'h0, 8'h00, 8'h01, 24'h000003};
    sum = 16'h0;
    for (int i = 0; i < 14; i++) sum += b[i*8 +: 8];
    attr_image = {b, sum};
  end
endmodule : ndatb_rw_model

// ===== verification/ndatb_chk_sva.sv
`timescale 1ns/1ps
module ndatb_chk (
  input logic core_clk,
  input logic rst,
  input logic verify_start,
  input logic resp_valid,
  input logic resp_last,
  input logic access_attr,
  input logic access_file,
  input logic ndef_enabled,
  input logic access_denied,
  input logic access_is_write,
  input logic attr_read_only,
  input logic [7:0] resp_byte,
  input logic [9:0] access_block,
  input logic [15:0] access_byte_addr,
  input logic [15:0] tag_system_code
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  a_resp_code: assert property (verify_start && !resp_valid |=> resp_valid && resp_byte == 8'h09)
    else $error("bad reply code");
  a_resp_len: assert property ($rose(resp_valid) |-> ##10 resp_last)
    else $error("reply length wrong");
  a_last_idle: assert property (resp_last |=> !resp_valid)
    else $error("reply overrun");
  a_byte_addr: assert property (access_byte_addr == {2'b00, access_block, 4'h0})
    else $error("byte address wrong");
  a_attr_blk: assert property (access_attr == (access_block == 10'h000 && ndef_enabled))
    else $error("attribute block decode");
  a_file_rng: assert property (access_file == (access_block inside {[1:59]} && ndef_enabled))
    else $error("file range decode");
  a_sys_code: assert property (ndef_enabled == (tag_system_code == 16'h12fc))
    else $error("system code decode");
  a_ro_deny: assert property (access_denied == (access_is_write && access_attr && attr_read_only))
    else $error("deny decode");
  c_reply: cover property (resp_last);
  c_deny: cover property (access_denied);
  c_file: cover property (access_file);
endmodule : ndatb_chk
bind ndatb_attr_block ndatb_chk u_chk (
  .core_clk(core_clk),
  .rst(rst),
  .verify_start(verify_start),
  .resp_valid(resp_valid),
  .resp_last(resp_last),
  .access_attr(access_attr),
  .access_file(access_file),
  .ndef_enabled(ndef_enabled),
  .access_denied(access_denied),
  .access_is_write(access_is_write),
  .attr_read_only(attr_read_only),
  .resp_byte(resp_byte),
  .access_block(access_block),
  .access_byte_addr(access_byte_addr),
  .tag_system_code(tag_system_code)
);

// ===== verification/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic core_clk = 0, rst = 1, attr_wr_en = 0, access_is_write = 0, verify_start = 0;
  logic [7:0] attr_wr_data = 0, status_flag1 = 8'ha5, status_flag2 = 8'h3c, resp_byte;
  logic [3:0] attr_wr_ofs = 0;
  logic [15:0] tag_system_code = 16'h12fc, access_byte_addr;
  logic [9:0] access_block = 0;
  logic [9:0] blks [4] = '{10'd0, 10'd1, 10'd59, 10'd60};
  logic [63:0] card_id = 64'h0123456789abcdef;
  logic resp_valid, resp_last, ndef_enabled, attr_valid, write_in_progress, attr_read_only;
  logic access_attr, access_file, access_denied;
  logic [127:0] attr_image;
  ndatb_pkg::ndatb_attr_s attr_info_block;
  int num_errors = 0, checks = 0;
  ndatb_attr_block uut (
    .core_clk(core_clk),
    .rst(rst),
    .attr_wr_data(attr_wr_data),
    .attr_wr_ofs(attr_wr_ofs),
    .attr_wr_en(attr_wr_en),
    .tag_system_code(tag_system_code),
    .access_block(access_block),
    .access_is_write(access_is_write),
    .verify_start(verify_start),
    .card_id(card_id),
    .status_flag1(status_flag1),
    .status_flag2(status_flag2),
    .resp_valid(resp_valid),
    .resp_byte(resp_byte),
    .resp_last(resp_last),
    .attr_info_block(attr_info_block),
    .ndef_enabled(ndef_enabled),
    .attr_valid(attr_valid),
    .write_in_progress(write_in_progress),
    .attr_read_only(attr_read_only),
    .access_attr(access_attr),
    .access_file(access_file),
    .access_denied(access_denied),
    .access_byte_addr(access_byte_addr)
  );
  ndatb_rw_model rw (.attr_image(attr_image));
  initial forever #4 core_clk = ~core_clk;
  task automatic chk(input logic [127:0] got, input logic [127:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] ofs, input logic [7:0] d);
    @(posedge core_clk) #1 attr_wr_en = 1;
    attr_wr_ofs = ofs;
    attr_wr_data = d;
    @(posedge core_clk) #1 attr_wr_en = 0;
  endtask : wr
  task automatic vfy;
    logic [87:0] exp;
    exp = {8'h09, card_id, status_flag1, status_flag2};
    @(posedge core_clk) #1 verify_start = 1;
    @(posedge core_clk) #1 verify_start = 0;
    for (int i = 0; i < 11; i++) begin
      chk({resp_valid, resp_last, resp_byte}, {1'b1, i == 10, exp[87-8*i -: 8]});
      @(posedge core_clk) #1;
    end
  endtask : vfy
  task automatic give_verdict;
    $display("errors=%0d checks=%0d", num_errors, checks);
    if (num_errors == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : give_verdict
  initial begin
    #20000;
    num_errors++;
    give_verdict();
  end
  initial begin
    repeat (12) @(posedge core_clk);
    #1 rst = 0;
    wr(0, 8'h77);
    chk({attr_read_only, attr_info_block.version}, 9'h100);
    wr(10, 8'h01);
    for (int i = 0; i < 16; i++) wr(i[3:0], attr_image[127-8*i -: 8]);
    chk(attr_info_block, {attr_image[127:88], attr_image[55:0]});
    chk({attr_valid, write_in_progress, attr_read_only}, 3'b100);
    wr(15, 8'h47);
    wr(9, 8'h0f);
    chk({attr_valid, write_in_progress}, 2'b01);
    foreach (blks[i]) begin
      @(posedge core_clk) #1 access_block = blks[i];
      #1 chk({access_attr, access_file, access_byte_addr},
        {blks[i] == 0, blks[i] inside {[1:59]}, 2'b00, blks[i], 4'h0});
    end
    @(posedge core_clk) #1 access_block = 10'd1;
    #1 chk(access_byte_addr, 16'h0010);
    wr(10, 8'h00);
    wr(0, 8'h77);
    access_block = 0;
    access_is_write = 1;
    #1 chk({access_denied, attr_info_block.version}, 9'h110);
    @(posedge core_clk) #1 tag_system_code = 16'h12fd;
    #1 chk({ndef_enabled, access_attr, access_denied}, 3'b000);
    vfy();
    card_id = ~card_id;
    vfy();
    give_verdict();
  end
endmodule : testbench
